//--- hw/dec_irq_alu.sv
`timescale 1ns/1ps
// Behaviour
// [RQ1] single decrement writes destination minus one, word or byte
// [RQ2] single decrement: negative flag follows result sign bit
// [RQ3] single decrement: zero set exactly when destination was one
// [RQ4] single decrement: carry cleared only when destination was zero
// [RQ5] single decrement: overflow only from 08000h word or 080h byte
// [RQ6] double decrement writes destination minus two, word or byte
// [RQ7] double decrement: negative flag follows result sign bit
// [RQ8] double decrement: zero set exactly when destination was two
// [RQ9] double decrement: carry cleared when destination was zero or one
// [RQ10] double decrement: overflow only from 08001h/08000h or 081h/080h
// [RQ11] decrements keep oscillator stop, halt and interrupt enable bits
// [RQ12] decrements use the subtractor with constant one or two
// [RQ13] interrupt disable ANDs status word with inverted 08h mask
// [RQ14] interrupt disable keeps arithmetic flags, oscillator and halt bits
// [RQ15] software puts one instruction after disable before protected code
// [RQ16] software never clears enable right after setting it
// [RQ17] spacing applies to every instruction clearing the enable bit
module dec_irq_alu
    import dec_alu_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [2:0] ctrl;
        logic [15:0] operand;
        logic [15:0] status_word;
        logic [15:0] result;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [15:0] sub_res;
    logic sub_n;
    logic sub_z;
    logic sub_c;
    logic sub_v;
    op_t cur_op;
    logic byte_sel;
    logic [15:0] sub_k;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == CTRL_OFFS) || (a == OPERAND_OFFS) || (a == STATUS_OFFS)
            || (a == RESULT_OFFS) || (a == FLAGS_OFFS);
    endfunction : mapped

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = m;
    endfunction : merge

    // the operation about to run comes from the word being written to the control register
    logic go_write;
    logic [31:0] ctrl_word;

    always_comb begin
        ctrl_word = merge({29'h0, st_r.ctrl}, st_r.w_data, st_r.w_strb);
        go_write = st_r.aw_held && st_r.w_held && !st_r.bvalid
            && (st_r.aw_addr == CTRL_OFFS) && ctrl_word[CTRL_GO_BIT];
        cur_op = op_t'(ctrl_word[CTRL_OP_LSB +: 2]);
        byte_sel = ctrl_word[CTRL_BYTE_BIT];
        sub_k = (cur_op == minus_two_op) ? SUB_TWO : SUB_ONE; // [RQ12]
    end

    dec_sub_core u_sub (
        .dst(st_r.operand),
        .k(sub_k),
        .byte_mode(byte_sel),
        .res(sub_res),
        .flag_n(sub_n),
        .flag_z(sub_z),
        .flag_c(sub_c),
        .flag_v(sub_v)
    );

    assign s_axi_awready = !st_r.aw_held;
    assign s_axi_wready = !st_r.w_held;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rdata = st_r.rdata;

    always_comb begin
        logic [31:0] wv;
        logic [15:0] sw;
        wv = 32'h0;
        sw = st_r.status_word;
        st_nxt = st_r;

        if (s_axi_awvalid && !st_r.aw_held) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_held) begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end

        // commit once both halves are held; response follows next cycle
        if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = mapped(st_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            unique case (st_r.aw_addr)
                CTRL_OFFS: begin
                    st_nxt.ctrl = ctrl_word[2:0];
                end
                OPERAND_OFFS: begin
                    wv = merge({16'h0, st_r.operand}, st_r.w_data, st_r.w_strb);
                    st_nxt.operand = wv[15:0];
                end
                STATUS_OFFS: begin
                    wv = merge({16'h0, st_r.status_word}, st_r.w_data, st_r.w_strb);
                    st_nxt.status_word = wv[15:0];
                end
                default: begin
                    // result and flags are read only; unmapped gets SLVERR
                end
            endcase
        end

        if (go_write) begin
            unique case (cur_op)
                minus_one_op, minus_two_op: begin
                    // destination replaced by the subtractor output
                    st_nxt.operand = sub_res; // [RQ1] [RQ6]
                    st_nxt.result = sub_res;
                    sw[SW_N_BIT] = sub_n; // [RQ2] [RQ7]
                    sw[SW_Z_BIT] = sub_z; // [RQ3] [RQ8]
                    sw[SW_C_BIT] = sub_c; // [RQ4] [RQ9]
                    sw[SW_V_BIT] = sub_v; // [RQ5] [RQ10]
                    // mode bits (gie, halt, oscillator) left as they were
                    st_nxt.status_word = sw; // [RQ11]
                end
                irq_mask_op: begin
                    // only the enable bit drops; pipeline hazard is software's to cover
                    st_nxt.status_word = st_r.status_word & ~IRQ_MASK_CONST; // [RQ13] [RQ14]
                end
                no_op: begin
                end
            endcase
        end

        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
        end

        if (st_r.rvalid) begin
            if (s_axi_rready) begin
                st_nxt.rvalid = 1'b0;
            end
        end else if (s_axi_arvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                CTRL_OFFS: st_nxt.rdata = {29'h0, st_r.ctrl};
                OPERAND_OFFS: st_nxt.rdata = {16'h0, st_r.operand};
                STATUS_OFFS: st_nxt.rdata = {16'h0, st_r.status_word};
                RESULT_OFFS: st_nxt.rdata = {16'h0, st_r.result};
                FLAGS_OFFS: st_nxt.rdata = {28'h0, st_r.status_word[SW_V_BIT],
                    st_r.status_word[SW_N_BIT], st_r.status_word[SW_Z_BIT],
                    st_r.status_word[SW_C_BIT]};
                default: st_nxt.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.operand <= OPERAND_RESET;
            st_r.status_word <= STATUS_RESET;
            st_r.ctrl <= 3'h3;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : dec_irq_alu

//--- hw/dec_alu_pkg.sv
package dec_alu_pkg;

    // register byte addresses (AXI4-Lite, one aligned word each)
    localparam logic [7:0] CTRL_OFFS = 8'h00;
    localparam logic [7:0] OPERAND_OFFS = 8'h04;
    localparam logic [7:0] STATUS_OFFS = 8'h08;
    localparam logic [7:0] RESULT_OFFS = 8'h0c;
    localparam logic [7:0] FLAGS_OFFS = 8'h10;

    // control register fields
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_BYTE_BIT = 2;
    localparam int CTRL_GO_BIT = 8;

    // status word bit positions
    localparam int SW_C_BIT = 0;
    localparam int SW_Z_BIT = 1;
    localparam int SW_N_BIT = 2;
    localparam int SW_GIE_BIT = 3;
    localparam int SW_PROCESSOR_HALT_BIT_BIT = 4;
    localparam int SW_OSCILLATOR_STOP_BIT_BIT = 5;
    localparam int SW_V_BIT = 8;

    localparam logic [15:0] IRQ_MASK_CONST = 16'h0008;
    localparam logic [15:0] SUB_ONE = 16'h0001;
    localparam logic [15:0] SUB_TWO = 16'h0002;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] OPERAND_RESET = 16'h0000;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        minus_one_op,
        minus_two_op,
        irq_mask_op,
        no_op
    } op_t;

endpackage : dec_alu_pkg

//--- hw/dec_sub_core.sv
`timescale 1ns/1ps
// general subtractor: dst - k in word or byte width, with flags
module dec_sub_core
    import dec_alu_pkg::*;
(
    input wire logic [15:0] dst,
    input wire logic [15:0] k,
    input wire logic byte_mode,
    output logic [15:0] res,
    output logic flag_n,
    output logic flag_z,
    output logic flag_c,
    output logic flag_v
);
    logic [16:0] diff;
    logic [15:0] d;
    logic sd;
    logic sk;
    logic sr;

    always_comb begin
        d = byte_mode ? {8'h00, dst[7:0]} : dst;
        // carry = no borrow: compute d + ~k + 1
        diff = {1'b0, d} + {1'b0, ~k} + 17'h00001;
        if (byte_mode) begin
            res = {8'h00, diff[7:0]};
            sd = d[7];
            sk = k[7];
            sr = diff[7];
            flag_c = (d[7:0] >= k[7:0]);
            flag_z = (diff[7:0] == 8'h00);
        end else begin
            res = diff[15:0];
            sd = d[15];
            sk = k[15];
            sr = diff[15];
            flag_c = diff[16];
            flag_z = (diff[15:0] == 16'h0000);
        end
        flag_n = sr; // [RQ2] [RQ7]
        // overflow: positive minus... operands of unlike sign and result sign flips
        flag_v = (sd != sk) && (sr != sd);
    end
endmodule : dec_sub_core

//--- verification/dec_irq_alu_monitor.sv
`timescale 1ns/1ps
module dec_irq_alu_chk
    import dec_alu_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic ar_take;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed");
    a_read_latency: assert property (ar_take |=> s_axi_rvalid)
        else $error("read answer not one cycle after address");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while answer pending");
    a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_unmapped_read: assert property (ar_take && s_axi_araddr > FLAGS_OFFS
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_result_width: assert property (ar_take && s_axi_araddr == RESULT_OFFS
        |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:16] == 16'h0)
        else $error("result read wider than sixteen bits");
    a_flags_width: assert property (ar_take && s_axi_araddr == FLAGS_OFFS
        |=> s_axi_rdata[31:4] == 28'h0)
        else $error("flags read carries stray bits");
    a_reset_idle: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && s_axi_arready)
        else $error("bus not idle after reset");
    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
    c_read_err: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_SLVERR);
    c_status_read: cover property (ar_take && s_axi_araddr == STATUS_OFFS);
endmodule : dec_irq_alu_chk

bind dec_irq_alu dec_irq_alu_chk u_chk (.*);

//--- verification/dec_irq_alu_tb.sv
`timescale 1ns/1ps
module dec_irq_alu_tb
    import dec_alu_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int err_total = 0;
    int comparisons = 0;
    logic [15:0] wv[6] = '{16'h0, 16'h1, 16'h2, 16'h8000, 16'h8001, 16'h1234};
    logic [15:0] bv[6] = '{16'hff00, 16'h1, 16'h2, 16'h80, 16'h81, 16'h34};

    dec_irq_alu dut (.*);

    initial begin
        forever #10 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // handshakes judged at the falling edge: nothing moves between it and the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tk;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        repeat (50) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tk = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tk) begin
                s_axi_bready <= 1'b0;
                chk(32'(r), 32'(er));
                return;
            end
        end
        chk(32'h1, 32'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] exp);
        logic ta, tk;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        repeat (50) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tk = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tk) begin
                s_axi_rready <= 1'b0;
                chk(32'(r), 32'(er));
                chk(d, exp);
                return;
            end
        end
        chk(32'h1, 32'h0);
    endtask : rd

    task automatic dec_case(input logic [1:0] op, input logic b, input logic [15:0] d);
        logic [15:0] k, m, sb, dm, res;
        logic [31:0] pre;
        logic n, z, c, v;
        k = (op == 2'h0) ? SUB_ONE : SUB_TWO;
        m = b ? 16'h00ff : 16'hffff;
        sb = b ? 16'h0080 : 16'h8000;
        pre = b ? 32'h30 : 32'h38;
        dm = d & m;
        res = (dm - k) & m;
        n = |(res & sb);
        z = (dm == k);
        c = (dm >= k);
        v = |(dm & sb) && !n;
        wr(OPERAND_OFFS, {16'h0, d}, RESP_OKAY);
        wr(STATUS_OFFS, pre, RESP_OKAY);
        wr(CTRL_OFFS, 32'h100 | {29'h0, b, op}, RESP_OKAY);
        rd(OPERAND_OFFS, RESP_OKAY, {16'h0, res});
        rd(RESULT_OFFS, RESP_OKAY, {16'h0, res});
        rd(STATUS_OFFS, RESP_OKAY, pre | {23'h0, v, 5'h0, n, z, c});
        rd(FLAGS_OFFS, RESP_OKAY, {28'h0, v, n, z, c});
    endtask : dec_case

    task automatic final_report();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    initial begin
        #400000;
        err_total++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OPERAND_OFFS, RESP_OKAY, 32'h0);
        rd(STATUS_OFFS, RESP_OKAY, 32'h0);
        for (int op = 0; op < 2; op++) begin
            for (int b = 0; b < 2; b++) begin
                for (int i = 0; i < 6; i++) begin
                    dec_case(op[1:0], b[0], b[0] ? bv[i] : wv[i]);
                end
            end
        end
        // interrupt disable: enable bit cleared, everything else kept, repeat is harmless
        wr(STATUS_OFFS, 32'h13f, RESP_OKAY);
        // a bus access always separates the disable from what follows; the status write of 13fh sets enable just before the first disable
        wr(CTRL_OFFS, 32'h102, RESP_OKAY);
        rd(STATUS_OFFS, RESP_OKAY, 32'h137);
        wr(CTRL_OFFS, 32'h102, RESP_OKAY);
        rd(STATUS_OFFS, RESP_OKAY, 32'h137);
        rd(OPERAND_OFFS, RESP_OKAY, 32'h32);
        wr(RESULT_OFFS, 32'hffff, RESP_OKAY);
        rd(RESULT_OFFS, RESP_OKAY, 32'h32);
        wr(8'h20, 32'h1, RESP_SLVERR);
        rd(8'h20, RESP_SLVERR, 32'h0);
        final_report();
    end
endmodule : dec_irq_alu_tb
